// file: smram_and_error_report_regs.sv
// smram decode controls, top of memory and sticky error reporting
`timescale 1ns/100ps
module smram_and_error_report_regs (
  // clock and resets
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       power_good,
  // configuration byte port
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  input  wire logic [7:0]                 cfg_addr,
  input  wire logic [7:0]                 cfg_wdata,
  output logic [7:0]                      cfg_rdata,
  output logic                            cfg_rd_ack,
  // state held in neighbouring registers
  input  wire logic                       global_smram_enable,
  input  wire logic                       smram_lock,
  input  wire logic                       smram_open,
  input  wire logic [4:0]                 low_usable_dram_top,
  input  wire logic                       pci_serr_enable,
  input  wire logic                       thermal_smi_enable,
  input  wire logic                       thermal_sci_enable,
  // processor requests and routing
  input  wire smram_err_pkg::cpu_req_t    cpu_req,
  output smram_err_pkg::route_t           route,
  // error events
  input  wire logic                       thermal_trip,
  input  wire logic                       refresh_enq,
  input  wire logic                       refresh_done,
  input  wire logic                       ecc_sbe,
  input  wire logic                       ecc_mbe,
  input  wire smram_err_pkg::ecc_log_t    ecc_info,
  output smram_err_pkg::ecc_log_t         ecc_log,
  // hub link messages
  output smram_err_pkg::hub_msg_t         hub_msg,
  input  wire logic                       hub_msg_ready
);
  import smram_err_pkg::*;

  logic rst_n;
  logic pg_rst_n;

  reset_release u_sys_rst (
    .clk_sys (clk_sys),
    .arst_n  (nrst),
    .srst_n  (rst_n)
  );

  // sticky state survives ordinary resets, only power loss clears it
  reset_release u_pg_rst (
    .clk_sys (clk_sys),
    .arst_n  (power_good),
    .srst_n  (pg_rst_n)
  );

  function automatic logic [35:0] seg_size(input logic [1:0] sz);
    case (sz)
      2'h0:    seg_size = SIZE_1MB;
      2'h1:    seg_size = SIZE_2MB;
      default: seg_size = SIZE_8MB;
    endcase
  endfunction : seg_size

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte

  // register state
  logic             high_en_reg, high_en_next;
  logic [1:0]       top_smram_segment_size_reg, top_smram_segment_size_next;
  logic             top_smram_segment_en_reg, top_smram_segment_en_next;
  logic             invalid_reg, invalid_next;
  logic [TOM_W-1:0] tom_reg, tom_next;
  logic [15:0]      serr_en_reg, serr_en_next;
  logic [15:0]      smi_en_reg, smi_en_next;
  logic [15:0]      sts_reg, sts_next;
  logic [15:0]      pend_reg, pend_next;
  logic [10:0]      rfq_reg, rfq_next;
  ecc_log_t         log_next;
  route_t           route_next;
  hub_msg_t         msg_next;
  logic [7:0]       rdata_next;

  // address decode
  logic        in_high, in_top_smram_segment, smm_ok, hit_high, hit_top_smram_segment, hit_low, bad_access;
  logic [35:0] low_usable_dram_top_addr, top_smram_segment_base;

  always_comb begin
    low_usable_dram_top_addr = {4'h0, low_usable_dram_top, 27'h0};
    top_smram_segment_base  = low_usable_dram_top_addr - seg_size(top_smram_segment_size_reg);
    in_high    = cpu_req.addr >= HIGH_BASE && cpu_req.addr <= HIGH_LAST;
    in_top_smram_segment    = cpu_req.addr >= top_smram_segment_base && cpu_req.addr < low_usable_dram_top_addr;
    smm_ok     = cpu_req.smm || (smram_open && !smram_lock);
    hit_high   = global_smram_enable && high_en_reg && in_high;
    hit_top_smram_segment   = global_smram_enable && top_smram_segment_en_reg && in_top_smram_segment
                 && top_smram_segment_size_reg != SZ_RESERVED;
    hit_low    = cpu_req.addr < low_usable_dram_top_addr;
    route_next.valid = cpu_req.valid;
    route_next.addr  = cpu_req.addr;
    if (hit_high) begin
      route_next.dram = smm_ok;
      if (smm_ok) begin
        route_next.addr = LEGACY_BASE | {19'h0, cpu_req.addr[WIN_BITS-1:0]};
      end
    end else if (hit_top_smram_segment) begin
      route_next.dram = smm_ok;
    end else begin
      route_next.dram = hit_low;
    end
    bad_access = cpu_req.valid && (hit_high || hit_top_smram_segment)
                 && !cpu_req.smm && !(smram_open && !smram_lock);
  end

  // config write strobes
  logic wr_esm, wr_tom_lo, wr_tom_hi, wr_sts_lo, wr_sts_hi;
  logic wr_serr_lo, wr_serr_hi, wr_smi_lo;

  always_comb begin
    wr_esm     = cfg_wr && cfg_addr == ADDR_ESMRAM;
    wr_tom_lo  = cfg_wr && cfg_addr == ADDR_TOM_LO;
    wr_tom_hi  = cfg_wr && cfg_addr == ADDR_TOM_HI;
    wr_sts_lo  = cfg_wr && cfg_addr == ADDR_STS_LO;
    wr_sts_hi  = cfg_wr && cfg_addr == ADDR_STS_HI;
    wr_serr_lo = cfg_wr && cfg_addr == ADDR_SERR_LO;
    wr_serr_hi = cfg_wr && cfg_addr == ADDR_SERR_HI;
    wr_smi_lo  = cfg_wr && cfg_addr == ADDR_SMI_LO;
  end

  // smram control and top of memory
  always_comb begin
    high_en_next   = high_en_reg;
    top_smram_segment_size_next = top_smram_segment_size_reg;
    top_smram_segment_en_next   = top_smram_segment_en_reg;
    tom_next       = tom_reg;
    if (wr_esm && !smram_lock) begin
      high_en_next   = cfg_wdata[ESM_HIGH_EN];
      top_smram_segment_size_next = cfg_wdata[ESM_SIZE_LSB +: 2];
      top_smram_segment_en_next   = cfg_wdata[ESM_TOP_SMRAM_SEGMENT_EN];
    end
    if (wr_tom_lo) begin
      tom_next[7:0] = cfg_wdata;
    end
    if (wr_tom_hi) begin
      tom_next[8] = cfg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_en_reg   <= 1'b0;
      top_smram_segment_size_reg <= 2'h0;
      top_smram_segment_en_reg   <= 1'b0;
      tom_reg       <= TOM_RESET;
    end else begin
      high_en_reg   <= high_en_next;
      top_smram_segment_size_reg <= top_smram_segment_size_next;
      top_smram_segment_en_reg   <= top_smram_segment_en_next;
      tom_reg       <= tom_next;
    end
  end

  // enables and refresh backlog
  logic rfq_full;

  always_comb begin
    serr_en_next = serr_en_reg;
    smi_en_next  = smi_en_reg;
    if (wr_serr_lo) begin
      serr_en_next[7:0] = cfg_wdata & STS_MASK[7:0];
    end
    if (wr_serr_hi) begin
      serr_en_next[15:8] = cfg_wdata & STS_MASK[15:8];
    end
    if (wr_smi_lo) begin
      smi_en_next[7:0] = cfg_wdata & SMI_MASK[7:0];
    end
    rfq_next = rfq_reg;
    rfq_full = rfq_reg == REFRESH_LIMIT;
    if (refresh_enq && !refresh_done && !rfq_full) begin
      rfq_next = rfq_reg + 11'h001;
    end else if (refresh_done && !refresh_enq && rfq_reg != 11'h000) begin
      rfq_next = rfq_reg - 11'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serr_en_reg <= 16'h0000;
      smi_en_reg  <= 16'h0000;
      rfq_reg     <= 11'h000;
    end else begin
      serr_en_reg <= serr_en_next;
      smi_en_reg  <= smi_en_next;
      rfq_reg     <= rfq_next;
    end
  end

  // sticky flags, logs and pending messages
  logic [15:0] ev, clr, serr_ok, smi_ok, sci_ok, any_ok, rise, sent;
  logic        thm_msg;

  always_comb begin
    serr_ok = serr_en_reg & {16{pci_serr_enable}};
    smi_ok  = smi_en_reg;
    sci_ok  = 16'h0000;
    smi_ok[FLG_THM] = thermal_smi_enable;
    sci_ok[FLG_THM] = thermal_sci_enable;
    any_ok  = serr_ok | smi_ok | sci_ok;
    // flag only when a message goes out
    thm_msg = thermal_trip && !sts_reg[FLG_THM] && any_ok[FLG_THM];
    ev = 16'h0000;
    ev[FLG_SBE] = ecc_sbe;
    ev[FLG_MBE] = ecc_mbe;
    ev[FLG_RTO] = refresh_enq && !refresh_done && rfq_reg == REFRESH_LIMIT - 11'h001;
    ev[FLG_LCK] = cpu_req.valid && cpu_req.lock && !route_next.dram;
    ev[FLG_THM] = thm_msg;
    clr = 16'h0000;
    if (wr_sts_lo) begin
      clr[7:0] = cfg_wdata;
    end
    if (wr_sts_hi) begin
      clr[15:8] = cfg_wdata;
    end
    sts_next = ((sts_reg & ~clr) | ev) & STS_MASK;
    rise     = ev & ~sts_reg & STS_MASK;
    invalid_next = bad_access || (invalid_reg && !(wr_esm && cfg_wdata[ESM_INVALID]));
    log_next = ecc_log;
    if (ecc_mbe && !sts_reg[FLG_MBE]) begin
      log_next = ecc_info;
    // single-bit logs only when nothing held
    end else if (ecc_sbe && !sts_reg[FLG_SBE] && !sts_reg[FLG_MBE]) begin
      log_next = ecc_info;
    end
  end

  // flags and logs live on power good
  always_ff @(posedge clk_sys or negedge pg_rst_n) begin
    if (!pg_rst_n) begin
      sts_reg     <= 16'h0000;
      invalid_reg <= 1'b0;
      ecc_log     <= '0;
    end else begin
      sts_reg     <= sts_next;
      invalid_reg <= invalid_next;
      ecc_log     <= log_next;
    end
  end

  // message sender: one pending bit per flag, lowest position first
  logic [3:0] pick;
  logic       have;
  logic       slot_free;

  always_comb begin
    pick = 4'h0;
    have = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = 4'(i);
        have = 1'b1;
      end
    end
    slot_free = !hub_msg.valid || hub_msg_ready;
    msg_next  = hub_msg;
    sent      = 16'h0000;
    if (hub_msg.valid && hub_msg_ready) begin
      msg_next.valid = 1'b0;
    end
    if (slot_free && have) begin
      sent[pick]     = 1'b1;
      msg_next.valid = 1'b1;
      msg_next.source = pick;
      if (serr_ok[pick]) begin
        msg_next.kind = MSG_SERR;
      end else if (smi_ok[pick]) begin
        msg_next.kind = MSG_SMI;
      end else begin
        msg_next.kind = MSG_SCI;
      end
    end
    pend_next = ((pend_reg & ~sent) | (rise & any_ok)) & STS_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 16'h0000;
      hub_msg  <= '0;
    end else begin
      pend_reg <= pend_next;
      hub_msg  <= msg_next;
    end
  end

  // registered route and config read
  logic [7:0] esm_view;

  always_comb begin
    esm_view = ESM_FIXED_ONES;
    esm_view[ESM_HIGH_EN] = high_en_reg;
    esm_view[ESM_INVALID] = invalid_reg;
    esm_view[ESM_SIZE_LSB +: 2] = top_smram_segment_size_reg;
    esm_view[ESM_TOP_SMRAM_SEGMENT_EN] = top_smram_segment_en_reg;
    unique case (cfg_addr)
      ADDR_ESMRAM:  rdata_next = esm_view;
      ADDR_TOM_LO:  rdata_next = tom_reg[7:0];
      ADDR_TOM_HI:  rdata_next = {7'h00, tom_reg[8]};
      ADDR_STS_LO:  rdata_next = pick_byte(sts_reg, 1'b0);
      ADDR_STS_HI:  rdata_next = pick_byte(sts_reg, 1'b1);
      ADDR_SERR_LO: rdata_next = pick_byte(serr_en_reg, 1'b0);
      ADDR_SERR_HI: rdata_next = pick_byte(serr_en_reg, 1'b1);
      ADDR_SMI_LO:  rdata_next = pick_byte(smi_en_reg, 1'b0);
      ADDR_SMI_HI:  rdata_next = pick_byte(smi_en_reg, 1'b1);
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata  <= 8'h00;
      cfg_rd_ack <= 1'b0;
      route      <= '0;
    end else begin
      cfg_rdata  <= cfg_rd ? rdata_next : 8'h00;
      cfg_rd_ack <= cfg_rd;
      route      <= route_next;
    end
  end

endmodule : smram_and_error_report_regs

// file: smram_err_pkg.sv
// constants, field layouts and carrier types for the smram and error register block
// Function
// - global and high smram enable remap high window onto dram a0000-bffff.
// - once locked, high enable, segment size and segment enable ignore writes.
// - non-smm access to high or top segment with open clear sets bit 6.
// - cacheable and both cache enable bits read 1; control resets to 38h.
// - size 00=1mb, 01=2mb, 10=8mb, 11 reserved; segment ends at usable top.
// - enabled top segment serves smm requests only; others go to hub link.
// - top segment decodes only with global enable and segment enable set.
// - nine-bit top of memory holds address 35:27; resets to 0001h.
// - serr message on flag rise when its enable and pci serr enable set.
// - flags other than thermal set regardless of enables and stay until software writes one.
// - thermal flag sets only if a message went; no message while set.
// - locked processor access that misses dram sets bit 9.
// - 1024 enqueued refreshes set refresh timeout bit 8.
// - multi-bit error sets bit 1, logs, then freezes logs until cleared.
// - single-bit error sets bit 0 and logs; later ones leave logs.
// - multi-bit error after pending single-bit overwrites logs; reverse does not.
// - error flags clear only on a software write of one or a power good reset.
// - serr enables at bits 11, 9, 8, 1, 0 gate messages; reset 0.
// - smi message for multi-bit error on bit 1, single-bit on bit 0.
// - lock forces open to 0; only full reset clears lock.
// - open set and lock clear make smm dram visible outside smm.
// - global enable required for extended functions; read only once locked.
package smram_err_pkg;

  // configuration byte addresses
  localparam logic [7:0]  ADDR_ESMRAM    = 8'h9e;
  localparam logic [7:0]  ADDR_TOM_LO    = 8'ha0;
  localparam logic [7:0]  ADDR_TOM_HI    = 8'ha1;
  localparam logic [7:0]  ADDR_STS_LO    = 8'hc8;
  localparam logic [7:0]  ADDR_STS_HI    = 8'hc9;
  localparam logic [7:0]  ADDR_SERR_LO   = 8'hca;
  localparam logic [7:0]  ADDR_SERR_HI   = 8'hcb;
  localparam logic [7:0]  ADDR_SMI_LO    = 8'hcc;
  localparam logic [7:0]  ADDR_SMI_HI    = 8'hcd;

  // extended smram control fields
  localparam int          ESM_HIGH_EN    = 7;
  localparam int          ESM_INVALID    = 6;
  localparam logic [7:0]  ESM_FIXED_ONES = 8'h38;
  localparam int          ESM_SIZE_LSB   = 1;
  localparam int          ESM_TOP_SMRAM_SEGMENT_EN    = 0;

  // top of memory
  localparam int          TOM_W          = 9;
  localparam logic [8:0]  TOM_RESET      = 9'h001;
  localparam int          TOM_SHIFT      = 27;
  localparam int          LOW_USABLE_DRAM_TOP_W        = 5;

  // error flag positions and masks
  localparam int          FLG_SBE        = 0;
  localparam int          FLG_MBE        = 1;
  localparam int          FLG_RTO        = 8;
  localparam int          FLG_LCK        = 9;
  localparam int          FLG_THM        = 11;
  localparam logic [15:0] STS_MASK       = 16'h0b03;
  localparam logic [15:0] SMI_MASK       = 16'h0003;

  // address windows
  localparam logic [35:0] HIGH_BASE      = 36'h0_feda_0000;
  localparam logic [35:0] HIGH_LAST      = 36'h0_fedb_ffff;
  localparam logic [35:0] LEGACY_BASE    = 36'h0_000a_0000;
  localparam int          WIN_BITS       = 17;
  localparam logic [35:0] SIZE_1MB       = 36'h0_0010_0000;
  localparam logic [35:0] SIZE_2MB       = 36'h0_0020_0000;
  localparam logic [35:0] SIZE_8MB       = 36'h0_0080_0000;
  localparam logic [1:0]  SZ_RESERVED    = 2'h3;

  // refresh backlog limit
  localparam logic [10:0] REFRESH_LIMIT  = 11'h400;

  typedef enum logic [1:0] {MSG_SERR, MSG_SMI, MSG_SCI} msg_type_t;

  typedef struct packed {
    logic        valid;
    logic [35:0] addr;
    logic        smm;
    logic        lock;
  } cpu_req_t;

  typedef struct packed {
    logic        valid;
    logic        dram;
    logic [35:0] addr;
  } route_t;

  typedef struct packed {
    logic [32:7] addr;
    logic        channel;
    logic [1:0]  device;
    logic [7:0]  syndrome;
  } ecc_log_t;

  typedef struct packed {
    logic       valid;
    msg_type_t  kind;
    logic [3:0] source;
  } hub_msg_t;

endpackage : smram_err_pkg

// file: reset_release.sv
// reset synchroniser: asynchronous assertion, two-flop release
`timescale 1ns/100ps
module reset_release (
  // clock and raw reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // released reset
  output logic      srst_n
);
  logic meta_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      srst_n   <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      srst_n   <= meta_reg;
    end
  end
endmodule : reset_release

// file: smram_err_monitor.sv
// concurrent checks on the smram and error register block ports
`timescale 1ns/100ps
module smram_err_monitor
  import smram_err_pkg::*;
(
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  // configuration port
  input wire logic                    cfg_rd,
  input wire logic [7:0]              cfg_addr,
  input wire logic [7:0]              cfg_rdata,
  input wire logic                    cfg_rd_ack,
  // decode and messages
  input wire logic                    global_smram_enable,
  input wire logic                    pci_serr_enable,
  input wire smram_err_pkg::cpu_req_t cpu_req,
  input wire smram_err_pkg::route_t   route,
  input wire smram_err_pkg::hub_msg_t hub_msg,
  input wire logic                    hub_msg_ready
);
  logic hi_win;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  assign hi_win = (cpu_req.addr >= HIGH_BASE) && (cpu_req.addr <= HIGH_LAST);

  AST_ESM_FIXED: assert property (cfg_rd && cfg_addr == ADDR_ESMRAM |=>
    cfg_rd_ack && cfg_rdata[5:3] == 3'h7) else $error("smram fixed bits not one");
  AST_TOM_HIGH: assert property (cfg_rd && cfg_addr == ADDR_TOM_HI |=>
    cfg_rdata[7:1] == 7'h00) else $error("top of memory high bits not zero");
  AST_STS_HIGH: assert property (cfg_rd && cfg_addr == ADDR_STS_HI |=>
    (cfg_rdata & 8'hf4) == 8'h00) else $error("status reserved bits set");
  AST_SMI_HIGH: assert property (cfg_rd && cfg_addr == ADDR_SMI_HI |=>
    cfg_rdata == 8'h00) else $error("smi enable high byte not zero");
  AST_REMAP: assert property (cpu_req.valid && hi_win |=> route.valid && (!route.dram ||
    (route.addr[35:WIN_BITS] == LEGACY_BASE[35:WIN_BITS] &&
     route.addr[16:0] == $past(cpu_req.addr[16:0])))) else $error("high window not remapped");
  AST_ROUTE_CAUSE: assert property ($rose(route.valid) |-> $past(cpu_req.valid))
    else $error("route without request");
  AST_NO_GLOBAL: assert property (cpu_req.valid && hi_win && !global_smram_enable |=>
    !route.dram) else $error("high window served without global enable");
  AST_MSG_HOLD: assert property (hub_msg.valid && !hub_msg_ready |=>
    hub_msg.valid && $stable(hub_msg)) else $error("message dropped before accept");
  AST_MSG_SRC: assert property (hub_msg.valid |->
    hub_msg.source inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hb}) else $error("bad message source");
  AST_SERR_GATE: assert property (hub_msg.valid && hub_msg.kind == MSG_SERR |->
    pci_serr_enable) else $error("serr sent while globally disabled");
endmodule : smram_err_monitor

// file: hub_link_model.sv
// hub link receiver model: accepts messages, can stall
`timescale 1ns/100ps
module hub_link_model
  import smram_err_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  // message link
  input  wire smram_err_pkg::hub_msg_t hub_msg,
  output logic                         hub_msg_ready,
  // stall control and record
  input  wire logic                    slow,
  output int                           n_msg,
  output smram_err_pkg::hub_msg_t      last_msg
);
  logic [1:0] phase_reg;
  // slow link takes one cycle in four, so senders must hold
  assign hub_msg_ready = !slow || (phase_reg == 2'h0);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
      n_msg     <= 0;
      last_msg  <= '0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (hub_msg.valid && hub_msg_ready) begin
        n_msg    <= n_msg + 1;
        last_msg <= hub_msg;
      end
    end
  end
endmodule : hub_link_model

// file: tb_smram_and_error_report_regs.sv
// self-checking testbench for the smram and error register block
`timescale 1ns/100ps
module tb_smram_and_error_report_regs;
  import smram_err_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       clk_sys, nrst, power_good, cfg_wr, cfg_rd, cfg_rd_ack, slow, hub_msg_ready;
  logic       global_smram_enable, smram_lock, smram_open, thermal_sci_enable, pci_serr_enable;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [3:0] ev;
  logic [35:0] sz, ra;
  cpu_req_t   cpu_req;
  route_t     route;
  ecc_log_t   ecc_info, ecc_log;
  ecc_log_t   la = '{26'h2a5_5aa5, 1'b1, 2'h2, 8'h5c};
  ecc_log_t   lb = '{26'h11c_3e07, 1'b0, 2'h1, 8'ha3};
  hub_msg_t   hub_msg, last;
  int         n_fail, comparisons, n_msg, n0;
  row_t rows [16] = '{'{0, 8'h9e, 0, 8'h38}, '{0, 8'ha0, 0, 8'h01}, '{0, 8'ha1, 0, 8'h00},
    '{0, 8'hc8, 0, 8'h00}, '{0, 8'hc9, 0, 8'h00}, '{0, 8'hca, 0, 8'h00},
    '{0, 8'hcb, 0, 8'h00}, '{0, 8'hcc, 0, 8'h00}, '{1, 8'ha0, 8'hff, 8'hff},
    '{1, 8'ha1, 8'hff, 8'h01}, '{1, 8'hc8, 8'hff, 8'h00}, '{1, 8'hc9, 8'hff, 8'h00},
    '{1, 8'hca, 8'hff, 8'h03}, '{1, 8'hcb, 8'hff, 8'h0b}, '{1, 8'hcd, 8'hff, 8'h00},
    '{1, 8'h50, 8'hff, 8'h00}};

  smram_and_error_report_regs DUT (.clk_sys, .nrst, .power_good, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .cfg_rd_ack, .global_smram_enable, .smram_lock, .smram_open,
    .low_usable_dram_top(5'h02), .pci_serr_enable, .thermal_smi_enable(1'b0),
    .thermal_sci_enable, .cpu_req, .route, .thermal_trip(ev[3]), .refresh_enq(ev[2]),
    .refresh_done(1'b0), .ecc_sbe(ev[0]), .ecc_mbe(ev[1]), .ecc_info, .ecc_log, .hub_msg,
    .hub_msg_ready);
  hub_link_model u_link (.clk_sys, .nrst, .hub_msg, .hub_msg_ready, .slow, .n_msg,
    .last_msg(last));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rdata", {1'b1, e}, {cfg_rd_ack, cfg_rdata});
    @(posedge clk_sys);
  endtask : rd

  task automatic req(logic [35:0] a, logic smm, logic lk, logic d);
    @(posedge clk_sys);
    cpu_req <= '{1'b1, a, smm, lk};
    @(posedge clk_sys);
    cpu_req <= '0;
    #1;
    ra = route.addr;
    chk("route.dram", {1'b1, d}, {route.valid, route.dram});
    @(posedge clk_sys);
  endtask : req

  task automatic evt(int b);
    @(posedge clk_sys);
    ev <= 4'h1 << b;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask : evt

  task automatic msg(int b, int x, msg_type_t k, logic [3:0] s);
    n0 = n_msg;
    evt(b);
    repeat (8) @(posedge clk_sys);
    chk("message count", n0 + x, n_msg);
    if (x != 0)
      chk("message", {k, s}, {last.kind, last.source});
  endtask : msg

  task automatic reset_pulse(logic full);
    @(posedge clk_sys);
    if (full)
      nrst <= 1'b0;
    else
      power_good <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst       <= 1'b1;
    power_good <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : reset_pulse

  // watchdog: whole run is under 1400 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end

  initial begin
    {nrst, power_good, cfg_wr, cfg_rd, slow, smram_lock, smram_open} = '0;
    {global_smram_enable, thermal_sci_enable, cfg_addr, cfg_wdata, ev} = '0;
    cpu_req  = '0;
    ecc_info = '0;
    pci_serr_enable = 1'b1;
    repeat (10) @(posedge clk_sys);
    nrst       <= 1'b1;
    power_good <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    global_smram_enable <= 1'b1;
    wr(8'h9e, 8'h81);
    req(36'h0_feda_1234, 1, 0, 1);
    chk("route.addr", 36'h0_000a_1234, ra);
    req(36'h0_feda_0000, 0, 0, 0);
    rd(8'h9e, 8'hf9);
    wr(8'h9e, 8'hc1);
    rd(8'h9e, 8'hb9);
    for (int s = 0; s < 4; s++) begin
      sz = (s == 0) ? SIZE_1MB : (s == 1) ? SIZE_2MB : SIZE_8MB;
      wr(8'h9e, 8'h81 | 8'(s << 1));
      req(36'h0_1000_0000 - sz, 0, 0, s == 3);
      req(36'h0_1000_0000 - sz - 36'h1, 0, 0, 1);
      req(36'h0_1000_0000 - sz, 1, 0, 1);
    end
    wr(8'h9e, 8'h80);
    req(36'h0_0ff0_0000, 0, 0, 1);
    smram_open <= 1'b1;
    req(36'h0_feda_0000, 0, 0, 1);
    global_smram_enable <= 1'b0;
    req(36'h0_feda_0000, 1, 0, 0);
    global_smram_enable <= 1'b1;
    wr(8'h9e, 8'h87);
    smram_lock <= 1'b1;
    req(36'h0_feda_0000, 0, 0, 0);
    wr(8'h9e, 8'h00);
    rd(8'h9e, 8'hff);
    smram_lock <= 1'b0;
    smram_open <= 1'b0;
    // serr then smi, one type per flag
    wr(8'hca, 8'h03);
    ecc_info <= la;
    msg(1, 1, MSG_SERR, 4'h1);
    chk("ecc_log", la, ecc_log);
    ecc_info <= lb;
    msg(0, 1, MSG_SERR, 4'h0);
    msg(1, 0, MSG_SERR, 4'h1);
    chk("ecc_log", la, ecc_log);
    rd(8'hc8, 8'h03);
    wr(8'hc8, 8'h03);
    rd(8'hc8, 8'h00);
    msg(0, 1, MSG_SERR, 4'h0);
    chk("ecc_log", lb, ecc_log);
    ecc_info <= la;
    msg(1, 1, MSG_SERR, 4'h1);
    chk("ecc_log", la, ecc_log);
    wr(8'hc8, 8'h03);
    pci_serr_enable <= 1'b0;
    msg(1, 0, MSG_SERR, 4'h1);
    rd(8'hc8, 8'h02);
    pci_serr_enable <= 1'b1;
    wr(8'hc8, 8'h03);
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'h00);
    wr(8'hcc, 8'h01);
    msg(0, 1, MSG_SMI, 4'h0);
    wr(8'hcc, 8'h02);
    msg(1, 1, MSG_SMI, 4'h1);
    wr(8'hcc, 8'h00);
    msg(3, 0, MSG_SCI, 4'hb);
    rd(8'hc9, 8'h00);
    // thermal uses sci only, never serr with smi
    thermal_sci_enable <= 1'b1;
    slow               <= 1'b1;
    msg(3, 1, MSG_SCI, 4'hb);
    msg(3, 0, MSG_SCI, 4'hb);
    rd(8'hc9, 8'h08);
    wr(8'hcb, 8'h02);
    req(36'h0_e000_0000, 0, 1, 0);
    repeat (8) @(posedge clk_sys);
    chk("message", {MSG_SERR, 4'h9}, {last.kind, last.source});
    rd(8'hc9, 8'h0a);
    ev <= 4'h4;
    repeat (1023) @(posedge clk_sys);
    ev <= 4'h0;
    rd(8'hc9, 8'h0a);
    evt(2);
    rd(8'hc9, 8'h0b);
    reset_pulse(1'b1);
    rd(8'hc9, 8'h0b);
    rd(8'ha0, 8'h01);
    reset_pulse(1'b0);
    rd(8'hc9, 8'h00);
    chk("ecc_log", 40'h0, ecc_log);
    summarize();
  end
endmodule : tb_smram_and_error_report_regs

bind smram_and_error_report_regs smram_err_monitor u_mon (.clk_sys, .nrst, .cfg_rd, .cfg_addr,
  .cfg_rdata, .cfg_rd_ack, .global_smram_enable, .pci_serr_enable, .cpu_req, .route, .hub_msg,
  .hub_msg_ready);
